//--- include/holding_reg_if.sv
// Holding register link between the master and the calibration register set
`timescale 1ns/10ps
interface holding_reg_if;
    logic req_valid;
    logic req_write;
    logic [15:0] req_addr;
    logic [15:0] req_wdata;
    logic rsp_valid;
    logic [15:0] rsp_rdata;

    modport device (
        input req_valid,
        input req_write,
        input req_addr,
        input req_wdata,
        output rsp_valid,
        output rsp_rdata
    );

    modport host (
        output req_valid,
        output req_write,
        output req_addr,
        output req_wdata,
        input rsp_valid,
        input rsp_rdata
    );
endinterface : holding_reg_if

//--- include/sensor_cal_pkg.sv
// Shared constants for the oxygen sensor calibration register set and its master
package sensor_cal_pkg;

    // ------------------------------------------------------------
    // Link and value widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int WORD_W = 16;
    localparam int VALUE_W = 32;
    localparam logic [15:0] PAIR_STEP = 16'h0001;

    // ------------------------------------------------------------
    // Holding register numbers, first register of each pair
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_SAMPLE_INTERVAL = 16'h0DAB;
    localparam logic [15:0] ADDR_ERROR_FLAGS = 16'h132B;
    localparam logic [15:0] ADDR_LOW_POINT_STATUS = 16'h1425;
    localparam logic [15:0] ADDR_LOW_POINT_TRIGGER = 16'h1429;
    localparam logic [15:0] ADDR_HIGH_POINT_STATUS = 16'h14C5;
    localparam logic [15:0] ADDR_HIGH_POINT_VALUE = 16'h14C9;
    localparam logic [15:0] ADDR_REFERENCE_MEASURE_TRIGGER = 16'h14DB;
    localparam logic [15:0] ADDR_ZERO_POINT_PHASE = 16'h1591;
    localparam logic [15:0] ADDR_ZERO_POINT_TEMPERATURE = 16'h1593;

    // ------------------------------------------------------------
    // Command and status values
    // ------------------------------------------------------------
    localparam logic [31:0] LOW_TRIGGER_VALUE = 32'h00000000;
    localparam logic [31:0] REFERENCE_TRIGGER_VALUE = 32'h00000001;
    localparam logic [31:0] LOW_STATUS_OK = 32'h00000000;
    localparam logic [31:0] LOW_STATUS_UNSTEADY = 32'h00000080;
    localparam logic [31:0] HIGH_STATUS_IDLE = 32'h00000000;
    localparam logic [31:0] HIGH_STATUS_ASSIGNED = 32'h14000000;
    localparam logic [31:0] NO_ERRORS = 32'h00000000;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] SAMPLE_INTERVAL_RESET = 32'h3F800000;
    localparam logic [31:0] VALUE_RESET = 32'h00000000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 200000000;
    localparam longint SETTLE_TIME_S = 30;
    localparam longint SETTLE_CYCLES = SETTLE_TIME_S * CLK_HZ;
    localparam int SETTLE_CNT_W = 33;

endpackage : sensor_cal_pkg

//--- rtl/sensor_cal_master.sv
// Master end: moves 32-bit values as register pairs, guarding calibration writes
`timescale 1ns/10ps
module sensor_cal_master #(
    parameter longint SETTLE_CYCLES = sensor_cal_pkg::SETTLE_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    holding_reg_if.host link,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [15:0] cmd_addr_i,
    input wire logic [31:0] cmd_wdata_i,
    output logic cmd_ready_o,
    output logic done_valid_o,
    output logic [31:0] done_data_o,
    output logic done_refused_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ERR_HI = 5'b00010,
        ST_ERR_LO = 5'b00100,
        ST_SETTLE = 5'b01000,
        ST_XFER = 5'b10000
    } master_st_t;

    typedef struct packed {
        master_st_t st;
        logic lo_phase;
        logic waiting;
        logic req_valid;
        logic req_write;
        logic [15:0] req_addr;
        logic [15:0] req_wdata;
        logic cmd_write;
        logic [15:0] cmd_addr;
        logic [31:0] cmd_wdata;
        logic [15:0] rd_hi;
        logic [sensor_cal_pkg::SETTLE_CNT_W-1:0] settle_cnt;
        logic ready;
        logic done_valid;
        logic [31:0] done_data;
        logic done_refused;
    } master_state_t;

    localparam logic [sensor_cal_pkg::SETTLE_CNT_W-1:0] SETTLE_LOAD =
        sensor_cal_pkg::SETTLE_CNT_W'(SETTLE_CYCLES);

    master_state_t state_q;
    master_state_t state_d;
    logic guarded;
    logic trigger;
    logic [31:0] err_word;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.req_valid = 1'b0;
        state_d.done_valid = 1'b0;
        err_word = {state_q.rd_hi, link.rsp_rdata};
        trigger = (state_q.cmd_addr == sensor_cal_pkg::ADDR_LOW_POINT_TRIGGER) ||
                  (state_q.cmd_addr == sensor_cal_pkg::ADDR_REFERENCE_MEASURE_TRIGGER);
        guarded = state_q.cmd_write && (trigger ||
                  (state_q.cmd_addr == sensor_cal_pkg::ADDR_ZERO_POINT_PHASE) ||
                  (state_q.cmd_addr == sensor_cal_pkg::ADDR_ZERO_POINT_TEMPERATURE) ||
                  (state_q.cmd_addr == sensor_cal_pkg::ADDR_HIGH_POINT_VALUE));
        // Interval settle timer, restarted by every interval write
        if (state_q.settle_cnt != '0) begin
            state_d.settle_cnt = state_q.settle_cnt - 1'b1;
        end
        case (state_q.st)
            ST_IDLE: begin
                if (cmd_valid_i && state_q.ready) begin
                    state_d.ready = 1'b0;
                    state_d.cmd_write = cmd_write_i;
                    state_d.cmd_addr = cmd_addr_i;
                    state_d.cmd_wdata = cmd_wdata_i;
                    state_d.lo_phase = 1'b0;
                    state_d.st = ST_ERR_HI;
                end
            end
            ST_ERR_HI, ST_ERR_LO: begin
                if (!guarded) begin
                    state_d.st = ST_XFER;
                end else if (!state_q.waiting) begin
                    // Error pair read ahead of any calibration write
                    state_d.req_valid = 1'b1;
                    state_d.req_write = 1'b0;
                    state_d.req_addr = (state_q.st == ST_ERR_HI) ? sensor_cal_pkg::ADDR_ERROR_FLAGS :
                                       sensor_cal_pkg::ADDR_ERROR_FLAGS + sensor_cal_pkg::PAIR_STEP;
                    state_d.waiting = 1'b1;
                end else if (link.rsp_valid) begin
                    state_d.waiting = 1'b0;
                    if (state_q.st == ST_ERR_HI) begin
                        state_d.rd_hi = link.rsp_rdata;
                        state_d.st = ST_ERR_LO;
                    end else if (err_word != sensor_cal_pkg::NO_ERRORS) begin
                        state_d.done_valid = 1'b1;
                        state_d.done_refused = 1'b1;
                        state_d.done_data = err_word;
                        state_d.ready = 1'b1;
                        state_d.st = ST_IDLE;
                    end else begin
                        // Environment conditions stay the user's duty
                        state_d.st = trigger ? ST_SETTLE : ST_XFER;
                    end
                end
            end
            ST_SETTLE: begin
                if (state_q.settle_cnt == '0) begin
                    state_d.st = ST_XFER;
                end
            end
            ST_XFER: begin
                if (!state_q.waiting) begin
                    state_d.req_valid = 1'b1;
                    state_d.req_write = state_q.cmd_write;
                    state_d.req_addr = state_q.lo_phase ? state_q.cmd_addr + sensor_cal_pkg::PAIR_STEP :
                                       state_q.cmd_addr;
                    state_d.req_wdata = state_q.lo_phase ? state_q.cmd_wdata[15:0] :
                                        state_q.cmd_wdata[31:16];
                    state_d.waiting = 1'b1;
                end else if (link.rsp_valid) begin
                    state_d.waiting = 1'b0;
                    if (!state_q.lo_phase) begin
                        state_d.rd_hi = link.rsp_rdata;
                        state_d.lo_phase = 1'b1;
                    end else begin
                        if (state_q.cmd_write && state_q.cmd_addr == sensor_cal_pkg::ADDR_SAMPLE_INTERVAL) begin
                            state_d.settle_cnt = SETTLE_LOAD;
                        end
                        // Status word goes back whole; retry on unsteady is the user's call
                        state_d.done_valid = 1'b1;
                        state_d.done_refused = 1'b0;
                        state_d.done_data = state_q.cmd_write ? state_q.cmd_wdata :
                                            {state_q.rd_hi, link.rsp_rdata};
                        state_d.ready = 1'b1;
                        state_d.st = ST_IDLE;
                    end
                end
            end
            default: begin
                state_d.st = ST_IDLE;
                state_d.ready = 1'b1;
                state_d.waiting = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_q <= '{
                st: ST_IDLE,
                lo_phase: 1'b0,
                waiting: 1'b0,
                req_valid: 1'b0,
                req_write: 1'b0,
                req_addr: 16'h0000,
                req_wdata: 16'h0000,
                cmd_write: 1'b0,
                cmd_addr: 16'h0000,
                cmd_wdata: 32'h00000000,
                rd_hi: 16'h0000,
                settle_cnt: SETTLE_LOAD,
                ready: 1'b1,
                done_valid: 1'b0,
                done_data: 32'h00000000,
                done_refused: 1'b0
            };
        end else begin
            state_q <= state_d;
        end
    end

    assign link.req_valid = state_q.req_valid;
    assign link.req_write = state_q.req_write;
    assign link.req_addr = state_q.req_addr;
    assign link.req_wdata = state_q.req_wdata;
    assign cmd_ready_o = state_q.ready;
    assign done_valid_o = state_q.done_valid;
    assign done_data_o = state_q.done_data;
    assign done_refused_o = state_q.done_refused;

endmodule : sensor_cal_master

//--- rtl/sensor_cal_regs.sv
// Calibration register set of the sensor, answering holding register accesses
`timescale 1ns/10ps
module sensor_cal_regs (
    input wire logic clk_i,
    input wire logic reset_n_i,
    holding_reg_if.device link,
    input wire logic [31:0] phase_i,
    input wire logic [31:0] temperature_i,
    input wire logic phase_steady_i,
    input wire logic [31:0] error_flags_i,
    output logic [31:0] sample_interval_o,
    output logic [31:0] zero_point_phase_o,
    output logic [31:0] zero_point_temperature_o,
    output logic [31:0] reference_phase_o,
    output logic [31:0] high_point_oxygen_value_o,
    output logic high_point_active_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic rsp_valid;
        logic [15:0] rsp_rdata;
        logic [15:0] hold_hi;
        logic [15:0] rd_lo;
        logic [31:0] sample_interval;
        logic [31:0] zero_phase;
        logic [31:0] zero_temp;
        logic [31:0] low_status;
        logic [31:0] ref_phase;
        logic ref_taken;
        logic [31:0] high_value;
        logic [31:0] high_status;
        logic high_active;
    } regs_state_t;

    regs_state_t state_q;
    regs_state_t state_d;

    // Decode of the register pair under request
    logic [15:0] base;
    logic is_hi;
    logic [31:0] wr_value;
    logic [31:0] rd_value;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.rsp_valid = 1'b0;
        state_d.rsp_rdata = 16'h0000;

        // Pair bases are odd numbers, the low half is the even one above
        is_hi = link.req_addr[0];
        base = link.req_addr - {15'h0000, ~link.req_addr[0]};
        wr_value = {state_q.hold_hi, link.req_wdata};
        rd_value = 32'h00000000;

        // Write-only and unmapped registers read back as zero
        case (base)
            sensor_cal_pkg::ADDR_SAMPLE_INTERVAL: begin
                rd_value = state_q.sample_interval;
            end
            sensor_cal_pkg::ADDR_ERROR_FLAGS: begin
                rd_value = error_flags_i;
            end
            sensor_cal_pkg::ADDR_LOW_POINT_STATUS: begin
                rd_value = state_q.low_status;
            end
            sensor_cal_pkg::ADDR_HIGH_POINT_STATUS: begin
                rd_value = state_q.high_status;
            end
            sensor_cal_pkg::ADDR_ZERO_POINT_PHASE: begin
                rd_value = state_q.zero_phase;
            end
            sensor_cal_pkg::ADDR_ZERO_POINT_TEMPERATURE: begin
                rd_value = state_q.zero_temp;
            end
            default: begin
                rd_value = 32'h00000000;
            end
        endcase

        if (link.req_valid) begin
            state_d.rsp_valid = 1'b1;
            if (!link.req_write) begin
                // High half read snapshots the low half so the pair stays coherent
                if (is_hi) begin
                    state_d.rsp_rdata = rd_value[31:16];
                    state_d.rd_lo = rd_value[15:0];
                end else begin
                    // A lone low read returns the last snapshot
                    state_d.rsp_rdata = state_q.rd_lo;
                end
            end else if (is_hi) begin
                // Nothing changes until the low half completes the value
                state_d.hold_hi = link.req_wdata;
            end else begin
                case (base)
                    sensor_cal_pkg::ADDR_SAMPLE_INTERVAL: begin
                        state_d.sample_interval = wr_value;
                    end

                    sensor_cal_pkg::ADDR_ZERO_POINT_PHASE: begin
                        state_d.zero_phase = wr_value;
                    end

                    sensor_cal_pkg::ADDR_ZERO_POINT_TEMPERATURE: begin
                        state_d.zero_temp = wr_value;
                    end

                    sensor_cal_pkg::ADDR_LOW_POINT_TRIGGER: begin
                        // Any other value is no command
                        if (wr_value == sensor_cal_pkg::LOW_TRIGGER_VALUE) begin
                            if (phase_steady_i) begin
                                state_d.zero_phase = phase_i;
                                state_d.zero_temp = temperature_i;
                                state_d.low_status = sensor_cal_pkg::LOW_STATUS_OK;
                            end else begin
                                // Old zero point kept while phase drifts
                                state_d.low_status = sensor_cal_pkg::LOW_STATUS_UNSTEADY;
                            end
                        end
                    end

                    sensor_cal_pkg::ADDR_REFERENCE_MEASURE_TRIGGER: begin
                        if (wr_value == sensor_cal_pkg::REFERENCE_TRIGGER_VALUE) begin
                            // A new reference voids any earlier assignment
                            state_d.ref_phase = phase_i;
                            state_d.ref_taken = 1'b1;
                            state_d.high_status = sensor_cal_pkg::HIGH_STATUS_IDLE;
                            state_d.high_active = 1'b0;
                        end
                    end

                    sensor_cal_pkg::ADDR_HIGH_POINT_VALUE: begin
                        state_d.high_value = wr_value;
                        // No reference yet: value kept, not assigned
                        if (state_q.ref_taken) begin
                            state_d.high_status = sensor_cal_pkg::HIGH_STATUS_ASSIGNED;
                            state_d.high_active = 1'b1;
                        end
                    end

                    default: begin
                        // Read-only and unmapped writes are dropped
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_q <= '{
                rsp_valid: 1'b0,
                rsp_rdata: 16'h0000,
                hold_hi: 16'h0000,
                rd_lo: 16'h0000,
                sample_interval: sensor_cal_pkg::SAMPLE_INTERVAL_RESET,
                zero_phase: sensor_cal_pkg::VALUE_RESET,
                zero_temp: sensor_cal_pkg::VALUE_RESET,
                low_status: sensor_cal_pkg::LOW_STATUS_OK,
                ref_phase: sensor_cal_pkg::VALUE_RESET,
                ref_taken: 1'b0,
                high_value: sensor_cal_pkg::VALUE_RESET,
                high_status: sensor_cal_pkg::HIGH_STATUS_IDLE,
                high_active: 1'b0
            };
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.rsp_valid = state_q.rsp_valid;
    assign link.rsp_rdata = state_q.rsp_rdata;

    assign sample_interval_o = state_q.sample_interval;
    assign zero_point_phase_o = state_q.zero_phase;
    assign zero_point_temperature_o = state_q.zero_temp;
    assign reference_phase_o = state_q.ref_phase;
    assign high_point_oxygen_value_o = state_q.high_value;
    assign high_point_active_o = state_q.high_active;

endmodule : sensor_cal_regs

//--- testbench/sensor_cal_chk.sv
// Checker on the holding register link between the master and the register set
`timescale 1ns/10ps
module sensor_cal_chk (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // ------------------------------------------------------------
    // Pair transfers: odd half first, even half three cycles later
    // ------------------------------------------------------------
    sequence hi_req_s(logic wr);
        req_valid && req_write == wr && req_addr[0];
    endsequence
    sequence lo_req_s(logic wr);
        ##3 req_valid && req_write == wr && req_addr == $past(req_addr, 3) + sensor_cal_pkg::PAIR_STEP;
    endsequence

    answer_one_cycle_a: assert property (req_valid |=> rsp_valid) else $error("request not answered");
    answer_has_cause_a: assert property (rsp_valid |-> $past(req_valid)) else $error("answer without request");
    request_waits_a: assert property (req_valid |=> !req_valid) else $error("request before answer");
    write_pair_order_a: assert property (hi_req_s(1'b1) |-> lo_req_s(1'b1)) else $error("write pair broken");
    read_pair_order_a: assert property (hi_req_s(1'b0) |-> lo_req_s(1'b0)) else $error("read pair broken");
    write_answer_zero_a: assert property (req_valid && req_write |=> rsp_rdata == 16'h0000)
        else $error("write answer not zero");
    low_status_code_a: assert property (req_valid && !req_write &&
        req_addr == sensor_cal_pkg::ADDR_LOW_POINT_STATUS + sensor_cal_pkg::PAIR_STEP
        |=> rsp_rdata inside {16'h0000, 16'h0080}) else $error("low status code out of set");
    high_status_code_a: assert property (req_valid && !req_write &&
        req_addr == sensor_cal_pkg::ADDR_HIGH_POINT_STATUS |=> rsp_rdata inside {16'h0000, 16'h1400})
        else $error("high status code out of set");
    wo_read_zero_a: assert property (req_valid && !req_write &&
        req_addr == sensor_cal_pkg::ADDR_LOW_POINT_TRIGGER |=> rsp_rdata == 16'h0000)
        else $error("write-only read not zero");
endmodule : sensor_cal_chk

//--- testbench/tb_oxygen_sensor_calibration_regs.sv
// Testbench joining master and register set, driving commands and sensor inputs
`timescale 1ns/10ps
module tb_oxygen_sensor_calibration_regs;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic cmd_write_i = 1'b0;
    logic phase_steady_i = 1'b0;
    logic [15:0] cmd_addr_i = 16'h0000;
    logic [31:0] cmd_wdata_i = 32'h00000000;
    logic [31:0] phase_i = 32'h00000000;
    logic [31:0] temperature_i = 32'h00000000;
    logic [31:0] error_flags_i = 32'h00000000;
    logic cmd_ready_o, done_valid_o, done_refused_o, high_point_active_o, rf;
    logic [31:0] done_data_o, sample_interval_o, zero_point_phase_o, zero_point_temperature_o;
    logic [31:0] reference_phase_o, high_point_oxygen_value_o, rd;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    always #2.5 clk_i = ~clk_i;

    holding_reg_if link_if();
    sensor_cal_regs sensor_cal_regs_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link_if.device),
        .phase_i(phase_i), .temperature_i(temperature_i), .phase_steady_i(phase_steady_i),
        .error_flags_i(error_flags_i), .sample_interval_o(sample_interval_o),
        .zero_point_phase_o(zero_point_phase_o), .zero_point_temperature_o(zero_point_temperature_o),
        .reference_phase_o(reference_phase_o), .high_point_oxygen_value_o(high_point_oxygen_value_o),
        .high_point_active_o(high_point_active_o));
    // Short settle count, so trigger waits stay at most 50 cycles
    sensor_cal_master #(.SETTLE_CYCLES(50)) sensor_cal_master_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .link(link_if.host), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i),
        .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o), .done_valid_o(done_valid_o),
        .done_data_o(done_data_o), .done_refused_o(done_refused_o));
    sensor_cal_chk sensor_cal_chk_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid(link_if.req_valid),
        .req_write(link_if.req_write), .req_addr(link_if.req_addr), .req_wdata(link_if.req_wdata),
        .rsp_valid(link_if.rsp_valid), .rsp_rdata(link_if.rsp_rdata));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit

    task automatic print_verdict();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // Entered at a rising edge; done_valid_o is sampled mid-cycle, clear of the edge
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [31:0] data);
        int n;
        cmd_valid_i <= 1'b1;
        cmd_write_i <= wr;
        cmd_addr_i <= addr;
        cmd_wdata_i <= data;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        @(negedge clk_i);
        check_bit(cmd_ready_o, 1'b0);
        n = 1;
        do begin
            @(negedge clk_i);
            n++;
        end while (done_valid_o !== 1'b1 && n < 400);
        check_bit(done_valid_o, 1'b1);
        check_bit(cmd_ready_o, 1'b1);
        rd = done_data_o;
        rf = done_refused_o;
        @(posedge clk_i);
    endtask : xfer

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        xfer(1'b0, sensor_cal_pkg::ADDR_SAMPLE_INTERVAL, 32'h00000000);
        check_word(rd, sensor_cal_pkg::SAMPLE_INTERVAL_RESET);
        xfer(1'b0, sensor_cal_pkg::ADDR_ERROR_FLAGS, 32'h00000000);
        check_word(rd, sensor_cal_pkg::NO_ERRORS);
        $display("test reset done");
    endtask : t_reset

    task automatic t_manual();
        xfer(1'b1, sensor_cal_pkg::ADDR_ZERO_POINT_PHASE, 32'h425D147B);
        check_bit(rf, 1'b0);
        xfer(1'b1, sensor_cal_pkg::ADDR_ZERO_POINT_TEMPERATURE, 32'h41AFD70A);
        check_word(zero_point_phase_o, 32'h425D147B);
        check_word(zero_point_temperature_o, 32'h41AFD70A);
        xfer(1'b0, sensor_cal_pkg::ADDR_ZERO_POINT_TEMPERATURE, 32'h00000000);
        check_word(rd, 32'h41AFD70A);
        $display("test manual done");
    endtask : t_manual

    task automatic t_refused();
        error_flags_i <= 32'h00010002;
        xfer(1'b1, sensor_cal_pkg::ADDR_ZERO_POINT_PHASE, 32'h11112222);
        check_bit(rf, 1'b1);
        check_word(rd, 32'h00010002);
        check_word(zero_point_phase_o, 32'h425D147B);
        error_flags_i <= 32'h00000000;
        $display("test refused done");
    endtask : t_refused

    task automatic t_low();
        xfer(1'b1, sensor_cal_pkg::ADDR_SAMPLE_INTERVAL, 32'h40400000);
        check_word(sample_interval_o, 32'h40400000);
        phase_i <= 32'h42100000;
        temperature_i <= 32'h41B00000;
        xfer(1'b1, sensor_cal_pkg::ADDR_LOW_POINT_TRIGGER, sensor_cal_pkg::LOW_TRIGGER_VALUE);
        xfer(1'b0, sensor_cal_pkg::ADDR_LOW_POINT_STATUS, 32'h00000000);
        check_word(rd, sensor_cal_pkg::LOW_STATUS_UNSTEADY);
        phase_steady_i <= 1'b1;
        xfer(1'b1, sensor_cal_pkg::ADDR_LOW_POINT_TRIGGER, sensor_cal_pkg::LOW_TRIGGER_VALUE);
        xfer(1'b0, sensor_cal_pkg::ADDR_LOW_POINT_STATUS, 32'h00000000);
        check_word(rd, sensor_cal_pkg::LOW_STATUS_OK);
        check_word(zero_point_phase_o, 32'h42100000);
        check_word(zero_point_temperature_o, 32'h41B00000);
        phase_i <= 32'h42500000;
        xfer(1'b1, sensor_cal_pkg::ADDR_LOW_POINT_TRIGGER, 32'h3F800000);
        check_word(zero_point_phase_o, 32'h42100000);
        xfer(1'b0, sensor_cal_pkg::ADDR_LOW_POINT_TRIGGER, 32'h00000000);
        check_word(rd, 32'h00000000);
        $display("test low point done");
    endtask : t_low

    task automatic t_high();
        phase_i <= 32'h42200000;
        xfer(1'b1, sensor_cal_pkg::ADDR_REFERENCE_MEASURE_TRIGGER, sensor_cal_pkg::REFERENCE_TRIGGER_VALUE);
        check_word(reference_phase_o, 32'h42200000);
        xfer(1'b0, sensor_cal_pkg::ADDR_HIGH_POINT_STATUS, 32'h00000000);
        check_word(rd, sensor_cal_pkg::HIGH_STATUS_IDLE);
        xfer(1'b1, sensor_cal_pkg::ADDR_HIGH_POINT_VALUE, 32'h41A73333);
        check_word(high_point_oxygen_value_o, 32'h41A73333);
        xfer(1'b0, sensor_cal_pkg::ADDR_HIGH_POINT_STATUS, 32'h00000000);
        check_word(rd, sensor_cal_pkg::HIGH_STATUS_ASSIGNED);
        check_bit(high_point_active_o, 1'b1);
        xfer(1'b0, 16'h0101, 32'h00000000);
        check_word(rd, 32'h00000000);
        $display("test high point done");
    endtask : t_high

    // Whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_manual();
        t_refused();
        t_low();
        t_high();
        print_verdict();
    end
endmodule : tb_oxygen_sensor_calibration_regs
